// [hw/level_sync.sv]
// Two-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the level is slow against the clock and glitches need no filtering.
`timescale 1ns/1ps

module level_sync (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Level
    input wire logic async_i,
    output logic sync_o
);

    logic first_reg;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            first_reg <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            first_reg <= async_i;
            sync_o <= first_reg;
        end
    end

endmodule : level_sync

// [hw/pci_power_mgmt_capability.sv]
// Power-management capability pair: capabilities word and control/status word.
// Assumes a configuration access path of one 16-bit word per strobe, byte lanes
// on be_i, a serial EEPROM loader on the same clock and a PCI reset pin.
//
// How it works
// [R1] Strap high at power-up reset release gives capabilities ffc2.
// [R2] Strap low at power-up reset release gives capabilities 7e02.
// [R3] EEPROM may override; strap low forces cold wake and aux current zero.
// [R4] Capability bits 14 to 11 always read one.
// [R5] Capability bits 10 and 9 always read one.
// [R6] Bits 8:6 report aux current, from strap and EEPROM.
// [R7] Capability bits 5, 4 and 3 always read zero.
// [R8] Capability bits 2:0 return fixed version 010.
// [R9] Internal hot-to-D0 reset leaves the control/status word untouched.
// [R10] With cold wake capable, PCI reset keeps wake flag and enable.
// [R11] Without cold wake, PCI reset clears flag, selector, enable and level; bits 14:13 show entry 0 scale.
// [R12] Wake flag sets on every wake event, enable or not, except during PCI reset without cold wake, where the clear wins.
// [R13] Writing one clears the flag and drops wake request unless a wake event comes in the same cycle; zero does nothing.
// [R14] Bits 14:13 show the scale of the selected data entry.
// [R15] Bits 12:9 are a read-only data selector, entries 0 to 7.
// [R16] Bit 8 enables wake; while clear no wake request is driven.
// [R17] Control/status bits 7:2 always read zero.
// [R18] Bits 1:0 are the writable power level, 00 D0 to 11 D3.
// [R19] Writes to read-only fields are ignored without side effects.
`timescale 1ns/1ps

module pci_power_mgmt_capability (
    // Clock and power-up reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Reset pins and internal resets
    input wire logic pci_reset_n_i,
    input wire logic hot_to_d0_reset_i,
    // Auxiliary supply strap pin
    input wire logic aux_present_i,
    // EEPROM loader
    input wire logic eeprom_load_i,
    input wire logic [15:0] eeprom_cap_i,
    input wire logic [15:0] eeprom_scale_i,
    // Configuration access
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_be_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic [15:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    // Power and wake
    input wire logic wake_event_i,
    output logic wake_req_o,
    output pm_cap_pkg::power_level_e device_power_level_o,
    output logic wake_from_cold_off_cap_o
);

    import pm_cap_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] settle_cnt;
        logic strap_taken;
        logic aux_strap;
        logic wake_from_cold_off_cap;
        logic [2:0] aux_current_need;
        logic [15:0] scale_table;
        logic [3:0] data_select;
        logic wake_event_flag;
        logic wake_assert_enable;
        power_level_e device_power_level;
        logic pci_reset_seen;
        logic [15:0] rdata;
        logic rvalid;
        logic wake_req;
    } state_s;

    localparam state_s STATE_RESET = '{
        settle_cnt: 2'h0,
        strap_taken: 1'b0,
        aux_strap: 1'b0,
        wake_from_cold_off_cap: CAP_REDUCED_DEFAULT[CAP_COLD_WAKE_BIT],
        aux_current_need: CAP_REDUCED_DEFAULT[CAP_AUX_HI:CAP_AUX_LO],
        scale_table: SCALE_TABLE_RESET,
        data_select: SELECT_RESET,
        wake_event_flag: 1'b0,
        wake_assert_enable: 1'b0,
        device_power_level: LEVEL_D0,
        pci_reset_seen: 1'b0,
        rdata: 16'h0000,
        rvalid: 1'b0,
        wake_req: 1'b0
    };

    state_s state_reg;
    state_s state_next;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic aux_sync;
    logic pci_reset_n_sync;

    level_sync aux_sync_inst (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(aux_present_i),
        .sync_o(aux_sync)
    );

    level_sync pci_reset_sync_inst (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(pci_reset_n_i),
        .sync_o(pci_reset_n_sync)
    );

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
        hits = (addr[7:1] == ofs[7:1]);
    endfunction : hits

    function automatic logic [1:0] scale_of(input logic [15:0] table_in,
                                            input logic [3:0] sel);
        logic [2:0] idx;
        idx = sel[2:0];
        if (sel > SELECT_LAST_VALID) begin
            scale_of = SCALE_RESET;
        end else begin
            scale_of = table_in[{idx, 1'b0} +: 2];
        end
    endfunction : scale_of

    // ------------------------------------------------------------------
    // Word images
    // ------------------------------------------------------------------
    logic [15:0] cap_word;
    logic [15:0] csr_word;

    always_comb begin
        cap_word = 16'h0000;
        cap_word[CAP_COLD_WAKE_BIT] = state_reg.wake_from_cold_off_cap;
        cap_word[CAP_HOT_WAKE_BIT:CAP_STATE0_WAKE_BIT] = 4'hf; // R4
        cap_word[CAP_STATE2_SUP_BIT] = 1'b1; // R5
        cap_word[CAP_STATE1_SUP_BIT] = 1'b1; // R5
        cap_word[CAP_AUX_HI:CAP_AUX_LO] = state_reg.aux_current_need; // R6
        cap_word[CAP_SPECIAL_INIT_BIT] = 1'b0; // R7
        cap_word[CAP_RESERVED_BIT] = 1'b0; // R7
        cap_word[CAP_WAKE_CLOCK_BIT] = 1'b0; // R7
        cap_word[2:0] = PM_SPEC_VERSION; // R8
    end

    always_comb begin
        csr_word = 16'h0000; // R17
        csr_word[CSR_WAKE_FLAG_BIT] = state_reg.wake_event_flag;
        csr_word[CSR_SCALE_HI:CSR_SCALE_LO] =
            scale_of(state_reg.scale_table, state_reg.data_select); // R14
        csr_word[CSR_SELECT_HI:CSR_SELECT_LO] = state_reg.data_select; // R15
        csr_word[CSR_WAKE_ENABLE_BIT] = state_reg.wake_assert_enable;
        csr_word[CSR_LEVEL_HI:CSR_LEVEL_LO] = state_reg.device_power_level;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic wr_cap;
    logic wr_csr;
    logic rd_cap;
    logic rd_csr;
    logic flag_clear;
    logic flag_set;
    logic pci_reset_edge;

    always_comb begin
        state_next = state_reg;

        wr_cap = cfg_wr_i && hits(cfg_addr_i, POWER_CAPABILITIES_OFS);
        wr_csr = cfg_wr_i && hits(cfg_addr_i, POWER_CONTROL_STATUS_OFS);
        rd_cap = cfg_rd_i && hits(cfg_addr_i, POWER_CAPABILITIES_OFS);
        rd_csr = cfg_rd_i && hits(cfg_addr_i, POWER_CONTROL_STATUS_OFS);
        flag_clear = wr_csr && cfg_be_i[1] && cfg_wdata_i[CSR_WAKE_FLAG_BIT]; // R13
        flag_set = wake_event_i; // R12
        pci_reset_edge = !pci_reset_n_sync && !state_reg.pci_reset_seen;

        // Strap capture once the synchroniser holds the pin's real level
        if (!state_reg.strap_taken) begin
            if (state_reg.settle_cnt == STRAP_SETTLE_CYCLES) begin
                state_next.strap_taken = 1'b1;
                state_next.aux_strap = aux_sync;
                if (aux_sync) begin
                    state_next.wake_from_cold_off_cap =
                        CAP_FULL_DEFAULT[CAP_COLD_WAKE_BIT]; // R1
                    state_next.aux_current_need =
                        CAP_FULL_DEFAULT[CAP_AUX_HI:CAP_AUX_LO]; // R1
                end else begin
                    state_next.wake_from_cold_off_cap =
                        CAP_REDUCED_DEFAULT[CAP_COLD_WAKE_BIT]; // R2
                    state_next.aux_current_need =
                        CAP_REDUCED_DEFAULT[CAP_AUX_HI:CAP_AUX_LO]; // R2
                end
            end else begin
                state_next.settle_cnt = state_reg.settle_cnt + 2'h1;
            end
        end

        // EEPROM override of the programmable capability fields
        if (eeprom_load_i && state_reg.strap_taken) begin
            state_next.scale_table = eeprom_scale_i;
            if (state_reg.aux_strap) begin
                state_next.wake_from_cold_off_cap =
                    eeprom_cap_i[CAP_COLD_WAKE_BIT]; // R3
                state_next.aux_current_need =
                    eeprom_cap_i[CAP_AUX_HI:CAP_AUX_LO]; // R3
            end else begin
                state_next.wake_from_cold_off_cap = 1'b0; // R3
                state_next.aux_current_need = 3'h0; // R3
            end
        end

        // Writes to the capabilities word are dropped: it is read-only
        if (wr_cap) begin
            state_next.wake_from_cold_off_cap = state_next.wake_from_cold_off_cap; // R19
        end

        // Control/status writes; selector and scale are read-only
        if (wr_csr) begin
            if (cfg_be_i[1]) begin
                state_next.wake_assert_enable =
                    cfg_wdata_i[CSR_WAKE_ENABLE_BIT]; // R16
            end
            if (cfg_be_i[0]) begin
                state_next.device_power_level =
                    power_level_e'(cfg_wdata_i[CSR_LEVEL_HI:CSR_LEVEL_LO]); // R18
            end
        end

        // Wake flag: an event in the clearing cycle keeps the flag set
        if (flag_set) begin
            state_next.wake_event_flag = 1'b1; // R12
        end else if (flag_clear) begin
            state_next.wake_event_flag = 1'b0; // R13
        end

        // PCI reset acts on every cycle of its assertion and holds the word cleared
        // Select and level always return to reset values;
        // flag and enable survive when cold wake is advertised
        state_next.pci_reset_seen = !pci_reset_n_sync;
        if (!pci_reset_n_sync) begin
            state_next.data_select = SELECT_RESET; // R11
            state_next.device_power_level = LEVEL_D0; // R11
            if (!state_reg.wake_from_cold_off_cap) begin
                state_next.wake_event_flag = 1'b0; // R11
                state_next.wake_assert_enable = 1'b0; // R11
            end else if (pci_reset_edge) begin
                state_next.wake_event_flag = state_next.wake_event_flag; // R10
                state_next.wake_assert_enable = state_reg.wake_assert_enable; // R10
            end
        end

        // The hot-to-D0 internal reset has no path into this word
        if (hot_to_d0_reset_i) begin
            state_next.device_power_level = state_next.device_power_level; // R9
        end

        // Wake request needs flag and enable; clears with the flag
        state_next.wake_req = state_next.wake_event_flag
                              && state_next.wake_assert_enable; // R16

        // Read path: one cycle after the strobe
        // Unmapped offsets read as zero; data holds until the next read
        state_next.rvalid = cfg_rd_i;
        if (rd_cap) begin
            state_next.rdata = cap_word;
        end else if (rd_csr) begin
            state_next.rdata = csr_word;
        end else if (cfg_rd_i) begin
            state_next.rdata = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cfg_rdata_o = state_reg.rdata;
    assign cfg_rvalid_o = state_reg.rvalid;
    assign wake_req_o = state_reg.wake_req;
    assign device_power_level_o = state_reg.device_power_level;
    assign wake_from_cold_off_cap_o = state_reg.wake_from_cold_off_cap;

endmodule : pci_power_mgmt_capability

// [hw/pm_cap_pkg.sv]
// Constants for the power-management capability pair in configuration space.
// Assumes a 16-bit word access path addressed by byte offset, bit 0 ignored.
package pm_cap_pkg;

    // ------------------------------------------------------------------
    // Offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] POWER_CAPABILITIES_OFS = 8'h46;
    localparam logic [7:0] POWER_CONTROL_STATUS_OFS = 8'h48;

    // ------------------------------------------------------------------
    // Capabilities word
    // ------------------------------------------------------------------
    localparam logic [15:0] CAP_FULL_DEFAULT = 16'hffc2;
    localparam logic [15:0] CAP_REDUCED_DEFAULT = 16'h7e02;
    localparam int CAP_COLD_WAKE_BIT = 15;
    localparam int CAP_HOT_WAKE_BIT = 14;
    localparam int CAP_STATE0_WAKE_BIT = 11;
    localparam int CAP_STATE2_SUP_BIT = 10;
    localparam int CAP_STATE1_SUP_BIT = 9;
    localparam int CAP_AUX_HI = 8;
    localparam int CAP_AUX_LO = 6;
    localparam int CAP_SPECIAL_INIT_BIT = 5;
    localparam int CAP_RESERVED_BIT = 4;
    localparam int CAP_WAKE_CLOCK_BIT = 3;
    localparam logic [2:0] PM_SPEC_VERSION = 3'h2;

    // ------------------------------------------------------------------
    // Control/status word
    // ------------------------------------------------------------------
    localparam int CSR_WAKE_FLAG_BIT = 15;
    localparam int CSR_SCALE_HI = 14;
    localparam int CSR_SCALE_LO = 13;
    localparam int CSR_SELECT_HI = 12;
    localparam int CSR_SELECT_LO = 9;
    localparam int CSR_WAKE_ENABLE_BIT = 8;
    localparam int CSR_LEVEL_HI = 1;
    localparam int CSR_LEVEL_LO = 0;
    localparam logic [3:0] SELECT_RESET = 4'h0;
    localparam logic [3:0] SELECT_LAST_VALID = 4'h7;
    localparam logic [1:0] SCALE_RESET = 2'h0;
    localparam logic [15:0] SCALE_TABLE_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Power levels and start-up
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LEVEL_D0 = 2'h0,
        LEVEL_D1 = 2'h1,
        LEVEL_D2 = 2'h2,
        LEVEL_D3 = 2'h3
    } power_level_e;

    // Cycles after power-up reset before the synchronised strap is trusted
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

endpackage : pm_cap_pkg

// [sim/pm_cap_chk.sv]
// Assertions on the power-management capability pair, bound to its top.
// Assumes only the ports of that top are visible.
`timescale 1ns/1ps

module pm_cap_chk import pm_cap_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic pci_reset_n_i,
    input wire logic hot_to_d0_reset_i,
    input wire logic eeprom_load_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_be_i,
    input wire logic [15:0] cfg_wdata_i,
    input wire logic [15:0] cfg_rdata_o,
    input wire logic wake_event_i,
    input wire logic wake_req_o,
    input wire power_level_e device_power_level_o,
    input wire logic wake_from_cold_off_cap_o
);
    logic [2:0] up_cnt_reg;
    logic [2:0] pci_hist_reg;
    logic quiet;
    logic cap_rd;
    logic csr_rd;
    logic csr_wr;
    // Quiet once power-up and PCI reset have both long settled
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_cnt_reg <= 3'h0;
            pci_hist_reg <= 3'h0;
        end else begin
            up_cnt_reg <= (up_cnt_reg == 3'h7) ? up_cnt_reg : up_cnt_reg + 3'h1;
            pci_hist_reg <= {pci_hist_reg[1:0], pci_reset_n_i};
        end
    end
    assign quiet = (up_cnt_reg == 3'h7) && (&pci_hist_reg) && pci_reset_n_i;
    assign cap_rd = cfg_rd_i && (cfg_addr_i[7:1] == POWER_CAPABILITIES_OFS[7:1]);
    assign csr_rd = cfg_rd_i && (cfg_addr_i[7:1] == POWER_CONTROL_STATUS_OFS[7:1]);
    assign csr_wr = cfg_wr_i && (cfg_addr_i[7:1] == POWER_CONTROL_STATUS_OFS[7:1]);

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_cap_ones;
        cap_rd |=> cfg_rdata_o[14:9] == 6'h3f;
    endproperty
    a_cap_ones: assert property (p_cap_ones)
        else $error("capability bits 14:9 not all one");
    property p_cap_low;
        cap_rd |=> cfg_rdata_o[5:0] == 6'h02;
    endproperty
    a_cap_low: assert property (p_cap_low)
        else $error("capability bits 5:0 wrong");
    property p_csr_zero;
        csr_rd |=> {cfg_rdata_o[12:9], cfg_rdata_o[7:2]} == 10'h000;
    endproperty
    a_csr_zero: assert property (p_csr_zero)
        else $error("control word fixed bits not zero");
    property p_wake_cause;
        $rose(wake_req_o) |-> $past(wake_event_i || (csr_wr && cfg_be_i[1] && cfg_wdata_i[8]));
    endproperty
    a_wake_cause: assert property (p_wake_cause)
        else $error("wake request rose without event or enable");
    property p_flag_clear;
        wake_req_o && csr_wr && cfg_be_i[1] && cfg_wdata_i[15] && !wake_event_i |=> !wake_req_o;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("wake request kept after clear");
    property p_level_write;
        csr_wr && cfg_be_i[0] && quiet |=> device_power_level_o == $past(cfg_wdata_i[1:0]);
    endproperty
    a_level_write: assert property (p_level_write)
        else $error("power level not taken from write");
    property p_hot_quiet;
        hot_to_d0_reset_i && quiet && !cfg_wr_i && !wake_event_i
            |=> $stable(device_power_level_o) && $stable(wake_req_o);
    endproperty
    a_hot_quiet: assert property (p_hot_quiet)
        else $error("internal reset disturbed control word");
    property p_sticky;
        wake_req_o && wake_from_cold_off_cap_o && !cfg_wr_i && !eeprom_load_i |=> wake_req_o;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sticky wake request lost");
    property p_pci_clear;
        !pci_reset_n_i [*5] |-> device_power_level_o == LEVEL_D0
            && (wake_from_cold_off_cap_o || !wake_req_o);
    endproperty
    a_pci_clear: assert property (p_pci_clear)
        else $error("PCI reset did not clear control word");
endmodule : pm_cap_chk

bind pci_power_mgmt_capability pm_cap_chk chk_u (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .pci_reset_n_i(pci_reset_n_i),
    .hot_to_d0_reset_i(hot_to_d0_reset_i), .eeprom_load_i(eeprom_load_i),
    .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
    .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .wake_event_i(wake_event_i), .wake_req_o(wake_req_o),
    .device_power_level_o(device_power_level_o),
    .wake_from_cold_off_cap_o(wake_from_cold_off_cap_o));

// [sim/pm_host_model.sv]
// Host side of configuration space: word reads and writes on request.
// Assumes the caller waits for each task to return before the next.
`timescale 1ns/1ps

module pm_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Configuration access
    output logic [7:0] cfg_addr_o,
    output logic cfg_rd_o,
    output logic cfg_wr_o,
    output logic [1:0] cfg_be_o,
    output logic [15:0] cfg_wdata_o,
    input wire logic [15:0] cfg_rdata_i,
    input wire logic cfg_rvalid_i
);
    initial begin
        cfg_addr_o = 8'h00;
        cfg_rd_o = 1'b0;
        cfg_wr_o = 1'b0;
        cfg_be_o = 2'h0;
        cfg_wdata_o = 16'h0000;
    end
    // Write one word; a one in bit 15 with be[1] set clears the wake flag unless a wake event coincides
    task automatic cfg_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge ref_clk_i);
        cfg_addr_o = a;
        cfg_be_o = be;
        cfg_wdata_o = d;
        cfg_wr_o = 1'b1;
        @(negedge ref_clk_i);
        cfg_wr_o = 1'b0;
        cfg_wdata_o = ~d;
        cfg_addr_o = ~a;
    endtask : cfg_write
    task automatic cfg_read(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(negedge ref_clk_i);
        cfg_addr_o = a;
        cfg_rd_o = 1'b1;
        @(negedge ref_clk_i);
        cfg_rd_o = 1'b0;
        d = cfg_rdata_i;
        v = cfg_rvalid_i;
        cfg_addr_o = ~a;
    endtask : cfg_read
endmodule : pm_host_model

// [sim/test_pci_power_mgmt_capability.sv]
// Self-checking bench for the power-management capability pair.
// Assumes the host model drives configuration space.
`timescale 1ns/1ps

module test_pci_power_mgmt_capability;
    import pm_cap_pkg::*;
    logic ref_clk_i, reset_n_i, pci_reset_n_i, hot_to_d0_reset_i, aux_present_i;
    logic eeprom_load_i, cfg_rd_i, cfg_wr_i, cfg_rvalid_o, wake_event_i, wake_req_o, cap15;
    logic [15:0] eeprom_cap_i, eeprom_scale_i, cfg_wdata_i, cfg_rdata_o, d, e, scale_tab;
    logic [7:0] cfg_addr_i;
    logic [1:0] cfg_be_i;
    power_level_e lvl;
    logic [31:0] rnd_state = 32'h7df2f1a4;
    int err_total = 0;
    int n_tests = 0;

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    pm_host_model host_u (.ref_clk_i(ref_clk_i), .cfg_addr_o(cfg_addr_i),
        .cfg_rd_o(cfg_rd_i), .cfg_wr_o(cfg_wr_i), .cfg_be_o(cfg_be_i),
        .cfg_wdata_o(cfg_wdata_i), .cfg_rdata_i(cfg_rdata_o), .cfg_rvalid_i(cfg_rvalid_o));
    pci_power_mgmt_capability dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .pci_reset_n_i(pci_reset_n_i), .hot_to_d0_reset_i(hot_to_d0_reset_i),
        .aux_present_i(aux_present_i), .eeprom_load_i(eeprom_load_i),
        .eeprom_cap_i(eeprom_cap_i), .eeprom_scale_i(eeprom_scale_i),
        .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_rvalid_o(cfg_rvalid_o), .wake_event_i(wake_event_i), .wake_req_o(wake_req_o),
        .device_power_level_o(lvl), .wake_from_cold_off_cap_o(cap15));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] xs();
        rnd_state ^= rnd_state << 13;
        rnd_state ^= rnd_state >> 17;
        rnd_state ^= rnd_state << 5;
        return rnd_state[15:0];
    endfunction : xs
    function automatic logic [15:0] csr_exp(input logic f, input logic en, input logic [1:0] l);
        return {f, scale_tab[1:0], 4'h0, en, 6'h00, l};
    endfunction : csr_exp
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string name);
        logic v;
        host_u.cfg_read(a, d, v);
        chk(name, exp, d);
        chk("rvalid", 16'h1, {15'h0, v});
    endtask : rd_chk
    task automatic powerup(input logic aux);
        @(negedge ref_clk_i);
        reset_n_i = 1'b0;
        aux_present_i = aux;
        scale_tab = 16'h0000;
        repeat (5) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
    endtask : powerup
    task automatic eeprom_load(input logic [15:0] c, input logic [15:0] s);
        @(negedge ref_clk_i);
        eeprom_cap_i = c;
        eeprom_scale_i = s;
        eeprom_load_i = 1'b1;
        @(negedge ref_clk_i);
        eeprom_load_i = 1'b0;
        eeprom_cap_i = ~c;
        eeprom_scale_i = ~s;
        scale_tab = s;
    endtask : eeprom_load
    task automatic pin_pulse(input int which, input int n);
        @(negedge ref_clk_i);
        if (which == 0) pci_reset_n_i = 1'b0;
        else if (which == 1) wake_event_i = 1'b1;
        else hot_to_d0_reset_i = 1'b1;
        repeat (n) @(negedge ref_clk_i);
        pci_reset_n_i = 1'b1;
        wake_event_i = 1'b0;
        hot_to_d0_reset_i = 1'b0;
        repeat (n) @(negedge ref_clk_i);
    endtask : pin_pulse
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (4000) @(posedge ref_clk_i);
        err_total++;
        print_verdict();
    end

    initial begin
        {reset_n_i, pci_reset_n_i, hot_to_d0_reset_i, aux_present_i} = 4'b0100;
        {eeprom_load_i, wake_event_i, eeprom_cap_i, eeprom_scale_i} = '0;
        powerup(1'b0);
        rd_chk(POWER_CAPABILITIES_OFS, CAP_REDUCED_DEFAULT, "caps low");
        chk("cap bit", {15'h0, CAP_REDUCED_DEFAULT[15]}, {15'h0, cap15});
        host_u.cfg_write(POWER_CAPABILITIES_OFS, 2'h3, 16'hffff);
        rd_chk(POWER_CAPABILITIES_OFS, CAP_REDUCED_DEFAULT, "caps write");
        eeprom_load(16'hffff, xs());
        rd_chk(POWER_CAPABILITIES_OFS, CAP_REDUCED_DEFAULT, "caps forced");
        rd_chk(8'h50, 16'h0000, "unmapped");
        for (int i = 0; i < 4; i++) begin
            e = xs();
            e[1:0] = 2'(i);
            host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h3, e);
            rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b0, e[8], e[1:0]), "csr");
            chk("level", {14'h0, e[1:0]}, {14'h0, lvl});
        end
        host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h3, 16'h8000);
        pin_pulse(1, 1);
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b1, 1'b0, 2'h0), "flag");
        chk("wake off", 16'h0, {15'h0, wake_req_o});
        host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h3, 16'h0102);
        chk("wake on", 16'h1, {15'h0, wake_req_o});
        host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h3, 16'h8102);
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b0, 1'b1, 2'h2), "clear");
        chk("wake clr", 16'h0, {15'h0, wake_req_o});
        pin_pulse(1, 1);
        pin_pulse(2, 2);
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b1, 1'b1, 2'h2), "hot");
        host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h1, 16'h8003);
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b1, 1'b1, 2'h3), "lane lo");
        host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h2, 16'h0000);
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b1, 1'b0, 2'h3), "lane hi");
        chk("wake lane", 16'h0, {15'h0, wake_req_o});
        pin_pulse(0, 6);
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b0, 1'b0, 2'h0), "pci low");
        fork
            host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h3, 16'h8000);
            pin_pulse(1, 1);
        join
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b1, 1'b0, 2'h0), "set wins");
        powerup(1'b1);
        rd_chk(POWER_CAPABILITIES_OFS, CAP_FULL_DEFAULT, "caps high");
        chk("cap bit", {15'h0, CAP_FULL_DEFAULT[15]}, {15'h0, cap15});
        host_u.cfg_write(POWER_CONTROL_STATUS_OFS, 2'h3, 16'h0103);
        pin_pulse(1, 1);
        pin_pulse(0, 6);
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b1, 1'b1, 2'h0), "sticky");
        e = xs();
        eeprom_load(e, xs());
        rd_chk(POWER_CAPABILITIES_OFS, {e[15], 6'h3f, e[8:6], 6'h02}, "caps prom");
        chk("cap bit", {15'h0, e[15]}, {15'h0, cap15});
        rd_chk(POWER_CONTROL_STATUS_OFS, csr_exp(1'b1, 1'b1, 2'h0), "scale");
        print_verdict();
    end
endmodule : test_pci_power_mgmt_capability
